/* design/config_word_decode_protect.sv */
// Configuration loader, option latch and external program access guard
//
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module config_word_decode_protect
  import cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [15:0] i_addr,
  input wire logic [13:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [13:0] o_rdata,
  // External programmer access
  input wire logic i_bulk_erase,
  input wire prog_req_s i_prog,
  input wire logic [13:0] i_mem_rdata,
  output logic o_mem_write,
  output logic [13:0] o_mem_addr,
  output logic [13:0] o_mem_wdata,
  output logic o_prog_rvalid,
  output logic [13:0] o_prog_rdata,
  // Core stack faults
  input wire logic i_stack_push_overflow,
  input wire logic i_stack_pop_underflow,
  output logic o_stack_reset,
  output logic o_stack_overflow_flag,
  output logic o_stack_underflow_flag,
  // Decoded options
  output cfg_options_s o_options
);

  // ------------------------------------------------------------
  // Cells and decode
  // ------------------------------------------------------------
  logic [13:0] word_one;
  logic [13:0] word_two;
  logic prog_one;
  logic prog_two;
  logic [13:0] cell_data;
  cfg_options_s decoded;

  function automatic logic is_cfg_addr(input logic [15:0] a);
    is_cfg_addr = (a == ADDR_CONFIG_ONE) || (a == ADDR_CONFIG_TWO);
  endfunction

  // Config writes come from the register port only
  assign prog_one = i_write && (i_addr == ADDR_CONFIG_ONE);
  assign prog_two = i_write && (i_addr == ADDR_CONFIG_TWO);
  assign cell_data = i_wdata;

  cfg_cells u_cells (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_erase(i_bulk_erase),
    .i_prog_one(prog_one),
    .i_prog_two(prog_two),
    .i_data(cell_data),
    .o_word_one(word_one),
    .o_word_two(word_two)
  );

  cfg_decode u_decode (
    .i_word_one(word_one),
    .i_word_two(word_two),
    .o_options(decoded)
  );

  // ------------------------------------------------------------
  // Option latch
  // ------------------------------------------------------------
  // Options are captured on the first clock after reset release and then
  // frozen, so config writes take effect only at the next reset.
  logic loaded;
  logic next_loaded;
  cfg_options_s options;
  cfg_options_s next_options;
  logic protect_live;

  // Protection follows the cells so an erase lifts it at once
  assign protect_live = ~word_one[PROTECT_BIT];

  always_comb begin
    next_loaded = 1'b1;
    next_options = options;
    if (!loaded) begin
      next_options = decoded;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      loaded <= 1'b0;
      options <= '0;
    end else begin
      loaded <= next_loaded;
      options <= next_options;
    end
  end

  // ------------------------------------------------------------
  // External program access guard
  // ------------------------------------------------------------
  // Only the external path is gated; the core fetch port bypasses this
  // block entirely
  logic mem_write;
  logic next_mem_write;
  logic [13:0] mem_addr;
  logic [13:0] next_mem_addr;
  logic [13:0] mem_wdata;
  logic [13:0] next_mem_wdata;
  logic rpend;
  logic next_rpend;
  logic rpend_blocked;
  logic next_rpend_blocked;
  logic prog_rvalid;
  logic next_prog_rvalid;
  logic [13:0] prog_rdata;
  logic [13:0] next_prog_rdata;

  always_comb begin
    next_mem_write = 1'b0;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    next_rpend = 1'b0;
    next_rpend_blocked = 1'b0;
    next_prog_rvalid = 1'b0;
    next_prog_rdata = prog_rdata;
    if (i_prog.req) begin
      next_mem_addr = i_prog.addr;
      next_mem_wdata = i_prog.wdata;
      if (i_prog.write) begin
        next_mem_write = ~protect_live;
      end else begin
        next_rpend = 1'b1;
        next_rpend_blocked = protect_live;
      end
    end
    // Memory answers in the same cycle the address is presented
    if (rpend) begin
      next_prog_rvalid = 1'b1;
      next_prog_rdata = rpend_blocked ? ZERO_WORD : i_mem_rdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mem_write <= 1'b0;
      mem_addr <= ZERO_WORD;
      mem_wdata <= ZERO_WORD;
      rpend <= 1'b0;
      rpend_blocked <= 1'b0;
      prog_rvalid <= 1'b0;
      prog_rdata <= ZERO_WORD;
    end else begin
      mem_write <= next_mem_write;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
      rpend <= next_rpend;
      rpend_blocked <= next_rpend_blocked;
      prog_rvalid <= next_prog_rvalid;
      prog_rdata <= next_prog_rdata;
    end
  end

  // ------------------------------------------------------------
  // Stack fault reset
  // ------------------------------------------------------------
  // Flags set regardless of enable; only the reset request is gated.
  // Flags clear only by the block reset, as the core reads them later.
  logic stack_reset;
  logic next_stack_reset;
  logic ovf_flag;
  logic next_ovf_flag;
  logic unf_flag;
  logic next_unf_flag;

  always_comb begin
    next_ovf_flag = ovf_flag | i_stack_push_overflow;
    next_unf_flag = unf_flag | i_stack_pop_underflow;
    next_stack_reset = loaded && options.stack_fault_reset_enable &&
                       (i_stack_push_overflow || i_stack_pop_underflow);
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      stack_reset <= 1'b0;
      ovf_flag <= 1'b0;
      unf_flag <= 1'b0;
    end else begin
      stack_reset <= next_stack_reset;
      ovf_flag <= next_ovf_flag;
      unf_flag <= next_unf_flag;
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  logic [13:0] rdata;
  logic [13:0] next_rdata;

  always_comb begin
    next_rdata = ZERO_WORD;
    if (i_read) begin
      if (i_addr == ADDR_CONFIG_ONE) begin
        next_rdata = word_one | UNIMPL_ONE;
      end else if (i_addr == ADDR_CONFIG_TWO) begin
        next_rdata = word_two | UNIMPL_TWO;
      end else if (i_addr == ADDR_STATUS) begin
        next_rdata[ST_PROTECT_BIT] = protect_live;
        next_rdata[ST_BUSY_BIT] = ~loaded;
      end else if (!is_cfg_addr(i_addr)) begin
        next_rdata = ZERO_WORD;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata <= ZERO_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;
  assign o_mem_write = mem_write;
  assign o_mem_addr = mem_addr;
  assign o_mem_wdata = mem_wdata;
  assign o_prog_rvalid = prog_rvalid;
  assign o_prog_rdata = prog_rdata;
  assign o_stack_reset = stack_reset;
  assign o_stack_overflow_flag = ovf_flag;
  assign o_stack_underflow_flag = unf_flag;
  assign o_options = options;

endmodule
`default_nettype wire

/* inc/cfg_pkg.sv */
// Constants, types and field layout for the configuration word decoder
// Operation
// - Unimplemented configuration bit positions always read back as one
// - Blank or bulk-erased cells read all ones, selecting each all-ones option
// - Clock output enable one gives pin I/O; zero drives instruction clock out
// - Brown-out field: 11 on, 10 off in sleep, 01 software, 00 off
// - Brown-out enable never turns on the power-up timer by itself
// - Active-low code protect bit enables protection when zero
// - Protection once enabled clears only through a bulk erase
// - Low-voltage programming on makes reset pin select ignored, pin stays reset
// - Reset pin select: one external reset with pull-up; zero digital input
// - Active-low power-up timer bit: one disables, zero enables
// - Watchdog field: 11 on, 10 off in sleep, 01 software, 00 off
// - Oscillator field: 11 high, 10 medium, 01 low external; 00 internal
// - Core fetches and reads program memory regardless of protection
// - Protection blocks external writes; external reads return zeros
// - Self-write region comes from its own field, not from code protection
// - Stack fault reset enable resets on overflow or underflow, setting flag
// - Configuration words sit at fixed adjacent addresses, word one first
package cfg_pkg;

  localparam int WORD_W = 14;
  localparam int ADDR_W = 16;

  // Register port addresses
  localparam logic [15:0] ADDR_CONFIG_ONE = 16'h8007;
  localparam logic [15:0] ADDR_CONFIG_TWO = 16'h8008;
  localparam logic [15:0] ADDR_STATUS = 16'h8009;

  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam logic [13:0] ZERO_WORD = 14'h0000;

  // Always-one masks of unimplemented bits
  localparam logic [13:0] UNIMPL_ONE = 14'h3104;
  localparam logic [13:0] UNIMPL_TWO = 14'h11fc;

  // Word one field positions
  localparam int CLOCK_OUT_BIT = 11;
  localparam int BROWNOUT_LSB = 9;
  localparam int PROTECT_BIT = 7;
  localparam int RESET_PIN_BIT = 6;
  localparam int POWERUP_BIT = 5;
  localparam int WATCHDOG_LSB = 3;
  localparam int OSC_LSB = 0;

  // Word two field positions
  localparam int LOW_VOLT_PROG_BIT = 13;
  localparam int LOW_POWER_BROWNOUT_BIT = 11;
  localparam int BROWNOUT_VOLT_BIT = 10;
  localparam int STV_BIT = 9;
  localparam int SELF_WRITE_LSB = 0;

  // Status bit positions
  localparam int ST_PROTECT_BIT = 0;
  localparam int ST_BUSY_BIT = 1;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOFTWARE = 2'b01,
    MODE_RUN_ONLY = 2'b10,
    MODE_ALWAYS = 2'b11
  } enable_mode_e;

  typedef enum logic [1:0] {
    OSC_INTERNAL = 2'b00,
    OSC_EXT_LOW = 2'b01,
    OSC_EXT_MEDIUM = 2'b10,
    OSC_EXT_HIGH = 2'b11
  } osc_mode_e;

  typedef struct packed {
    logic clock_output_enable;
    enable_mode_e brownout_mode;
    logic code_protected;
    logic reset_pin_is_reset;
    logic reset_pin_pullup_forced;
    logic powerup_timer_on;
    enable_mode_e watchdog_mode;
    osc_mode_e osc_mode;
    logic clock_input_pin_is_io;
    logic low_voltage_prog_enable;
    logic low_power_brownout_sel;
    logic brownout_voltage_sel;
    logic stack_fault_reset_enable;
    logic [1:0] self_write_protect_sel;
  } cfg_options_s;

  typedef struct packed {
    logic req;
    logic write;
    logic [13:0] addr;
    logic [13:0] wdata;
  } prog_req_s;

endpackage

/* design/cfg_cells.sv */
// Nonvolatile configuration cell model with erase and one-way programming
`timescale 1ns/1ns
`default_nettype none
module cfg_cells
  import cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Cell control
  input wire logic i_erase,
  input wire logic i_prog_one,
  input wire logic i_prog_two,
  input wire logic [13:0] i_data,
  // Cell contents
  output logic [13:0] o_word_one,
  output logic [13:0] o_word_two
);

  logic [13:0] word_one;
  logic [13:0] word_two;
  logic [13:0] next_word_one;
  logic [13:0] next_word_two;

  // Programming only clears bits, like real flash; writes wait out reset
  always_comb begin
    next_word_one = word_one;
    next_word_two = word_two;
    if (i_erase) begin
      next_word_one = ERASED_WORD;
      next_word_two = ERASED_WORD;
    end else if (!i_reset) begin
      // A cleared protect bit cannot be set again by programming
      if (i_prog_one) begin
        next_word_one = (word_one & i_data) | UNIMPL_ONE;
      end
      if (i_prog_two) begin
        next_word_two = (word_two & i_data) | UNIMPL_TWO;
      end
    end
  end

  // Nonvolatile: a block reset must not lift protection, only an erase
  always_ff @(posedge i_clk) begin
    word_one <= next_word_one;
    word_two <= next_word_two;
  end

  assign o_word_one = word_one;
  assign o_word_two = word_two;

endmodule
`default_nettype wire

/* design/cfg_decode.sv */
// Combinational decode of the two configuration words into options
`timescale 1ns/1ns
`default_nettype none
module cfg_decode
  import cfg_pkg::*;
(
  // Configuration words
  input wire logic [13:0] i_word_one,
  input wire logic [13:0] i_word_two,
  // Decoded options
  output cfg_options_s o_options
);

  always_comb begin
    // Raw bit: one leaves the pin as I/O, zero drives the clock out
    o_options.clock_output_enable = i_word_one[CLOCK_OUT_BIT];
    o_options.brownout_mode = enable_mode_e'(i_word_one[BROWNOUT_LSB +: 2]);
    o_options.code_protected = ~i_word_one[PROTECT_BIT];
    // Low-voltage programming keeps the pin as reset
    o_options.reset_pin_is_reset = i_word_two[LOW_VOLT_PROG_BIT] | i_word_one[RESET_PIN_BIT];
    o_options.reset_pin_pullup_forced = o_options.reset_pin_is_reset;
    // Independent of the brown-out field
    o_options.powerup_timer_on = ~i_word_one[POWERUP_BIT];
    o_options.watchdog_mode = enable_mode_e'(i_word_one[WATCHDOG_LSB +: 2]);
    o_options.osc_mode = osc_mode_e'(i_word_one[OSC_LSB +: 2]);
    o_options.clock_input_pin_is_io = (i_word_one[OSC_LSB +: 2] == OSC_INTERNAL);
    o_options.low_voltage_prog_enable = i_word_two[LOW_VOLT_PROG_BIT];
    o_options.low_power_brownout_sel = i_word_two[LOW_POWER_BROWNOUT_BIT];
    o_options.brownout_voltage_sel = i_word_two[BROWNOUT_VOLT_BIT];
    o_options.stack_fault_reset_enable = i_word_two[STV_BIT];
    // Passed raw; erased 11 means no self-write protection
    o_options.self_write_protect_sel = i_word_two[SELF_WRITE_LSB +: 2];
  end

endmodule
`default_nettype wire

/* tb/cfg_protect_asserts.sv */
// Port checker for the configuration decoder
`timescale 1ns/1ns
`default_nettype none
module cfg_protect_asserts
  import cfg_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Watched ports
  input wire logic [15:0] i_addr,
  input wire logic [13:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [13:0] o_rdata,
  input wire logic i_bulk_erase,
  input wire prog_req_s i_prog,
  input wire logic o_mem_write,
  input wire logic o_prog_rvalid,
  input wire logic [13:0] o_prog_rdata,
  input wire logic i_stack_push_overflow,
  input wire logic o_stack_reset,
  input wire logic o_stack_overflow_flag,
  input wire cfg_options_s o_options
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  logic loaded;
  logic prot;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      loaded <= 1'b0;
    end else begin
      loaded <= 1'b1;
    end
  end
  // Live protection seen from writes; erase wins, and it outlasts reset
  always_ff @(posedge i_clk) begin
    prot <= !i_bulk_erase && (prot || (i_write && !i_reset && i_addr == ADDR_CONFIG_ONE && !i_wdata[PROTECT_BIT]));
  end
  chk_word_one_ones: assert property (
    i_read && i_addr == ADDR_CONFIG_ONE |=> (o_rdata & UNIMPL_ONE) == UNIMPL_ONE)
    else $error("word one unimplemented bit low");
  chk_word_two_ones: assert property (
    i_read && i_addr == ADDR_CONFIG_TWO |=> (o_rdata & UNIMPL_TWO) == UNIMPL_TWO)
    else $error("word two unimplemented bit low");
  chk_prog_read_delay: assert property (
    i_prog.req && !i_prog.write |-> ##2 o_prog_rvalid)
    else $error("programmer read not answered");
  chk_prot_no_write: assert property (
    i_prog.req && i_prog.write && prot && !i_bulk_erase |=> !o_mem_write)
    else $error("protected write passed");
  chk_open_write: assert property (
    i_prog.req && i_prog.write && !prot |=> o_mem_write)
    else $error("unprotected write dropped");
  chk_prot_read_zero: assert property (
    o_prog_rvalid && prot && $past(prot, 2) |-> o_prog_rdata == ZERO_WORD)
    else $error("protected read leaked data");
  chk_options_hold: assert property (
    loaded |=> $stable(o_options))
    else $error("options changed after load");
  chk_stack_flag: assert property (
    i_stack_push_overflow |=> o_stack_overflow_flag)
    else $error("overflow flag not set");
  chk_stack_reset: assert property (
    i_stack_push_overflow && o_options.stack_fault_reset_enable |=> o_stack_reset)
    else $error("stack reset missing");
  chk_stack_gated: assert property (
    !o_options.stack_fault_reset_enable |=> !o_stack_reset)
    else $error("stack reset while disabled");
  chk_lvp_pin: assert property (
    loaded && o_options.low_voltage_prog_enable |-> o_options.reset_pin_is_reset)
    else $error("reset pin lost reset role");
  chk_osc_pin: assert property (
    loaded |-> o_options.clock_input_pin_is_io == (o_options.osc_mode == OSC_INTERNAL))
    else $error("clock input pin role wrong");
endmodule
bind config_word_decode_protect cfg_protect_asserts i_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_bulk_erase(i_bulk_erase),
  .i_prog(i_prog), .o_mem_write(o_mem_write), .o_prog_rvalid(o_prog_rvalid),
  .o_prog_rdata(o_prog_rdata), .i_stack_push_overflow(i_stack_push_overflow),
  .o_stack_reset(o_stack_reset), .o_stack_overflow_flag(o_stack_overflow_flag),
  .o_options(o_options));
`default_nettype wire

/* tb/prog_mem_model.sv */
// Program memory model behind the external access guard
`timescale 1ns/1ns
`default_nettype none
module prog_mem_model (
  // Clock
  input wire logic i_clk,
  // Access from the guard
  input wire logic i_write,
  input wire logic [13:0] i_addr,
  input wire logic [13:0] i_wdata,
  output logic [13:0] o_rdata
);
  // Upper address bits alias; sixteen words suffice here
  logic [13:0] mem [16];
  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 14'h0a00 + 14'(i);
    end
  end
  always @(posedge i_clk) begin
    if (i_write) begin
      mem[i_addr[3:0]] <= i_wdata;
    end
  end
  assign o_rdata = mem[i_addr[3:0]];
endmodule
`default_nettype wire

/* tb/test_config_word_decode_protect.sv */
// Self-checking bench for the configuration decoder
`timescale 1ns/1ns
`default_nettype none
module test_config_word_decode_protect
  import cfg_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [15:0] i_addr = '0;
  logic [13:0] i_wdata = '0;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  // Cells outlast reset, so the run starts from an erased part
  logic i_bulk_erase = 1'b1;
  prog_req_s i_prog = '0;
  logic i_stack_push_overflow = 1'b0;
  logic i_stack_pop_underflow = 1'b0;
  logic [13:0] o_rdata, i_mem_rdata, o_mem_addr, o_mem_wdata, o_prog_rdata;
  logic o_mem_write, o_prog_rvalid, o_stack_reset, o_stack_overflow_flag, o_stack_underflow_flag;
  cfg_options_s o_options;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;

  config_word_decode_protect i_dut (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write),
    .i_read(i_read), .o_rdata(o_rdata), .i_bulk_erase(i_bulk_erase), .i_prog(i_prog),
    .i_mem_rdata(i_mem_rdata), .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_prog_rvalid(o_prog_rvalid), .o_prog_rdata(o_prog_rdata),
    .i_stack_push_overflow(i_stack_push_overflow), .i_stack_pop_underflow(i_stack_pop_underflow),
    .o_stack_reset(o_stack_reset), .o_stack_overflow_flag(o_stack_overflow_flag),
    .o_stack_underflow_flag(o_stack_underflow_flag), .o_options(o_options));
  prog_mem_model i_mem (
    .i_clk(i_clk), .i_write(o_mem_write), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
    .o_rdata(i_mem_rdata));

  always #5 i_clk = ~i_clk;

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string name, input logic [13:0] exp, input logic [13:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [13:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clk);
    i_write <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [13:0] e, input string name);
    @(posedge i_clk);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clk);
    i_read <= 1'b0;
    #1 cmp(name, e, o_rdata);
  endtask
  // Write expects the pulse flag, read expects the returned word
  task automatic pr(input logic w, input logic [13:0] a, input logic [13:0] d, input logic [13:0] e);
    @(posedge i_clk);
    i_prog <= '{1'b1, w, a, d};
    @(posedge i_clk);
    i_prog.req <= 1'b0;
    #1 if (w) cmp("mem write", e, 14'(o_mem_write));
    cmp("mem addr", a, o_mem_addr);
    cmp("mem wdata", d, o_mem_wdata);
    @(posedge i_clk);
    #1 if (!w) cmp("prog read", e, o_prog_rvalid ? o_prog_rdata : ERASED_WORD);
  endtask
  task automatic stack(input logic over, input logic rst);
    @(posedge i_clk);
    i_stack_push_overflow <= over;
    i_stack_pop_underflow <= !over;
    @(posedge i_clk);
    i_stack_push_overflow <= 1'b0;
    i_stack_pop_underflow <= 1'b0;
    #1 cmp("stack reset", 14'(rst), 14'(o_stack_reset));
    cmp("stack flag", 14'h1, 14'(over ? o_stack_overflow_flag : o_stack_underflow_flag));
  endtask

  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      test_done;
    end
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    i_bulk_erase <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    cmp("clock out", 14'h1, 14'(o_options.clock_output_enable));
    cmp("brownout mode", 14'h3, 14'(o_options.brownout_mode));
    cmp("protect", 14'h0, 14'(o_options.code_protected));
    cmp("pin reset", 14'h1, 14'(o_options.reset_pin_is_reset));
    cmp("powerup timer", 14'h0, 14'(o_options.powerup_timer_on));
    cmp("watchdog mode", 14'h3, 14'(o_options.watchdog_mode));
    cmp("osc mode", 14'h3, 14'(o_options.osc_mode));
    cmp("clock in io", 14'h0, 14'(o_options.clock_input_pin_is_io));
    cmp("self write sel", 14'h3, 14'(o_options.self_write_protect_sel));
    cmp("stack en", 14'h1, 14'(o_options.stack_fault_reset_enable));
    cmp("pin pullup", 14'h1, 14'(o_options.reset_pin_pullup_forced));
    cmp("low volt prog", 14'h1, 14'(o_options.low_voltage_prog_enable));
    cmp("low power brownout", 14'h1, 14'(o_options.low_power_brownout_sel));
    cmp("brownout volt", 14'h1, 14'(o_options.brownout_voltage_sel));
    rd(ADDR_CONFIG_ONE, ERASED_WORD, "word one");
    rd(ADDR_CONFIG_TWO, ERASED_WORD, "word two");
    rd(16'h8006, ZERO_WORD, "unmapped");
    rd(ADDR_STATUS, ZERO_WORD, "status");
    pr(1'b1, 14'h0005, 14'h1234, 14'h0001);
    pr(1'b0, 14'h0005, ZERO_WORD, 14'h1234);
    wr(ADDR_CONFIG_ONE, 14'h3f7f);
    rd(ADDR_CONFIG_ONE, 14'h3f7f, "protect clear");
    rd(ADDR_STATUS, 14'h0001, "live protect");
    wr(ADDR_CONFIG_ONE, ZERO_WORD);
    wr(ADDR_CONFIG_TWO, ZERO_WORD);
    rd(ADDR_CONFIG_ONE, UNIMPL_ONE, "ones one");
    rd(ADDR_CONFIG_TWO, UNIMPL_TWO, "ones two");
    wr(ADDR_CONFIG_ONE, ERASED_WORD);
    rd(ADDR_CONFIG_ONE, UNIMPL_ONE, "no unprotect");
    pr(1'b1, 14'h0006, 14'h0abc, ZERO_WORD);
    pr(1'b0, 14'h0005, ZERO_WORD, ZERO_WORD);
    cmp("frozen", 14'h0, 14'(o_options.code_protected));
    stack(1'b1, 1'b1);
    stack(1'b0, 1'b1);
    // Second reset: the programmed words now reach the options
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk);
    #1 cmp("clock out on", 14'h0, 14'(o_options.clock_output_enable));
    cmp("brownout off", 14'h0, 14'(o_options.brownout_mode));
    cmp("protect on", 14'h1, 14'(o_options.code_protected));
    cmp("pin input", 14'h0, 14'(o_options.reset_pin_is_reset));
    cmp("pullup ctl", 14'h0, 14'(o_options.reset_pin_pullup_forced));
    cmp("powerup on", 14'h1, 14'(o_options.powerup_timer_on));
    cmp("watchdog off", 14'h0, 14'(o_options.watchdog_mode));
    cmp("osc internal", 14'h0, 14'(o_options.osc_mode));
    cmp("clock in io on", 14'h1, 14'(o_options.clock_input_pin_is_io));
    cmp("low volt off", 14'h0, 14'(o_options.low_voltage_prog_enable));
    cmp("stack off", 14'h0, 14'(o_options.stack_fault_reset_enable));
    cmp("self write zero", 14'h0, 14'(o_options.self_write_protect_sel));
    cmp("flag cleared", 14'h0, 14'(o_stack_overflow_flag));
    rd(ADDR_STATUS, 14'h0001, "kept protect");
    stack(1'b1, 1'b0);
    @(posedge i_clk);
    i_bulk_erase <= 1'b1;
    @(posedge i_clk);
    i_bulk_erase <= 1'b0;
    rd(ADDR_CONFIG_ONE, ERASED_WORD, "erased");
    rd(ADDR_STATUS, ZERO_WORD, "lifted");
    cmp("frozen erase", 14'h1, 14'(o_options.code_protected));
    pr(1'b0, 14'h0006, ZERO_WORD, 14'h0a06);
    test_done;
  end
endmodule
`default_nettype wire
